// File: ssarb_pkg.sv
// Package: register map, field positions, reset values and types of the serial slave register bank
`default_nettype none
package ssarb_pkg;
  // Bus addresses
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h28;
  // Register offsets
  localparam logic [7:0] OFF_ALERT_SUMMARY = 8'h0b;
  localparam logic [7:0] OFF_ALERT_MASK = 8'h0c;
  localparam logic [7:0] OFF_CONN_CHANGE = 8'h0d;
  localparam logic [7:0] OFF_CONN_STATE = 8'h0e;
  localparam logic [7:0] OFF_MON_CHANGE = 8'h0f;
  localparam logic [7:0] OFF_MON_STATE = 8'h10;
  localparam logic [7:0] OFF_PORT_OP_STATE = 8'h11;
  localparam logic [7:0] OFF_FAULT_CHANGE = 8'h12;
  localparam logic [7:0] OFF_FAULT_STATE = 8'h13;
  localparam logic [7:0] OFF_ADV_CAP = 8'h18;
  localparam logic [7:0] OFF_AUX_ILIM = 8'h1e;
  localparam logic [7:0] OFF_AUX_MON = 8'h20;
  localparam logic [7:0] OFF_VBUS_RANGE = 8'h22;
  localparam logic [7:0] OFF_SW_RESET = 8'h23;
  localparam logic [7:0] OFF_DISCH_TIME = 8'h25;
  localparam logic [7:0] OFF_DISCH_STATE = 8'h26;
  localparam logic [7:0] OFF_PWR_PATH = 8'h27;
  localparam logic [7:0] OFF_PWR_MODE = 8'h28;
  localparam logic [7:0] OFF_VBUS_MON = 8'h2e;
  // Field positions
  localparam int BIT_CONN_ALERT = 6;
  localparam int BIT_MON_ALERT = 5;
  localparam int BIT_FAULT_ALERT = 4;
  localparam int BIT_ATTACH_CHG = 0;
  // Reset values
  localparam logic [7:0] RST_MASK_RSVD = 8'h8f;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] ALERT_BITS = 8'h70;
  // Attachment codes
  localparam logic [2:0] ATT_NONE = 3'h0;
  localparam logic [2:0] ATT_SINK = 3'h1;
  localparam logic [2:0] ATT_SOURCE = 3'h2;
  localparam logic [2:0] ATT_DEBUG = 3'h3;
  localparam logic [2:0] ATT_AUDIO = 3'h4;
  // Port state codes
  localparam logic [4:0] PSC_UNATT_SRC = 5'h08;
  localparam logic [4:0] PSC_UNORIENTED_DBG = 5'h10;
  localparam logic [4:0] PSC_ORIENTED_DBG = 5'h19;
  // Timing: 10 MHz clock; glitch filter length in cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam logic [1:0] FILT_MAX = 2'(FILT_CYCLES);
  // Channel pin termination as seen by the analog front end
  typedef enum logic [1:0] {CC_OPEN, CC_RD, CC_RA} ssarb_term_e;
  typedef struct packed {
    logic [2:0] attachment_type;
    logic standby;
    logic role_indicator;
    logic aux_supply_active;
    logic attach_state_bit;
  } ssarb_conn_s;
endpackage
`default_nettype wire

// File: ssarb_top.sv
// Serial slave port, register bank, alert logic and source-role debug accessory detection
//
// Summary of operation
// - Source role: both channel pins terminated by Rd means debug accessory.
// - Enter unoriented debug, then oriented once one pin shows at most Ra.
// - Debug detection raises indicator, reports orientation and state code.
// - Slave only on the two-wire bus, up to 400 kbit/s.
// - All bytes travel most significant bit first, both directions.
// - Address 0x28 or 0x29; lsb comes from the address select pin.
// - Serial data input is filtered against short glitches.
// - 8-bit register address byte, one 8-bit data byte per register.
// - Read-and-clear registers return contents then go to zero.
// - Read-write registers store writes; read-only and reserved ignore writes.
// - Reset loads listed defaults; user-defined defaults come from storage.
// - Any unmasked change flag sets its summary alert bit 6, 5 or 4.
// - Mask bit 1 blocks its summary alert bit; 0 leaves it active.
// - Alert output low when summary AND NOT mask is nonzero.
// - Alert masks default to 1 from storage; reserved mask bits read 1.
// - Attach change flag latches on attach bit change, clears on read.
// - Connection state bits 7:5 encode the attachment type.
// - Bit 4 shows standby mode, default from storage.
// - Bit 3 shows role, bit 1 shows auxiliary supply active.
// - Registers at 0Bh to 2Eh; gaps, 2Fh and 00h-0Ah read-only reserved.
`default_nettype none
module ssarb_top (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_pin_i,
  input wire logic [2:0] nvm_alert_mask_i,
  input wire logic nvm_standby_i,
  input wire logic role_source_i,
  input wire logic aux_supply_active_i,
  input wire logic [2:0] attach_mode_i,
  input wire logic [3:0] mon_state_i,
  input wire logic [7:0] fault_state_i,
  input wire logic [7:0] fault_event_i,
  input wire logic [1:0] channel_pin_one_i,
  input wire logic [1:0] channel_pin_two_i,
  output logic alert_b_o,
  output logic source_debug_indicator_o,
  output logic orient_oe_o,
  output logic [7:0] sw_reset_o,
  output logic [7:0] port_power_mode_o
);
  // ==========================================================
  // Input synchronisers and glitch filter
  localparam logic [1:0] FILT_MAX_L = ssarb_pkg::FILT_MAX;
  logic [1:0] scl_sync_reg, sda_sync_reg, asel_sync_reg;
  logic scl_reg, sda_f_reg;
  logic [1:0] sda_cnt_reg;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      asel_sync_reg <= 2'b00;
      scl_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      asel_sync_reg <= {asel_sync_reg[0], address_select_pin_i};
      scl_reg <= scl_sync_reg[1];
    end
  end
  // Data line only changes after holding steady for the filter length
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sda_f_reg <= 1'b1;
      sda_cnt_reg <= 2'b00;
    end
    else if (sda_sync_reg[1] == sda_f_reg)
      sda_cnt_reg <= 2'b00;
    else if (sda_cnt_reg == FILT_MAX_L - 2'd1)
    begin
      sda_f_reg <= sda_sync_reg[1];
      sda_cnt_reg <= 2'b00;
    end
    else
      sda_cnt_reg <= sda_cnt_reg + 2'd1;
  end
  wire scl_s = scl_sync_reg[1];
  wire scl_rise = scl_s & ~scl_reg;
  wire scl_fall = ~scl_s & scl_reg;
  logic sda_prev_reg;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sda_prev_reg <= 1'b1;
    else
      sda_prev_reg <= sda_f_reg;
  end
  wire start_det = scl_s & scl_reg & sda_prev_reg & ~sda_f_reg;
  wire stop_det = scl_s & scl_reg & ~sda_prev_reg & sda_f_reg;

  // ==========================================================
  // Serial slave state machine
  typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_ACK, ST_REGADDR, ST_WDATA, ST_RDATA, ST_RACK} ssarb_st_e;
  ssarb_st_e st_reg, st_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic phase_reg, phase_next; // 0: device address byte received, 1: register address or data byte
  logic [7:0] rd_sh_reg, rd_sh_next;
  logic drv_reg, drv_next;
  logic wr_stb, rd_stb;
  logic [7:0] rd_data;
  wire [6:0] my_addr = {ssarb_pkg::SLAVE_ADDR_BASE[6:1], asel_sync_reg[1]};
  wire [7:0] rx_byte = {shift_reg[6:0], sda_f_reg};
  always_comb
  begin
    st_next = st_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    phase_next = phase_reg;
    rd_sh_next = rd_sh_reg;
    drv_next = drv_reg;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    if (start_det)
    begin
      st_next = ST_DEVADDR;
      bit_next = 3'd0;
      drv_next = 1'b0;
    end
    else if (stop_det)
    begin
      st_next = ST_IDLE;
      drv_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        ST_IDLE: ;
        ST_DEVADDR, ST_REGADDR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_next = rx_byte;
            bit_next = bit_reg + 3'd1;
          end
          if (scl_rise && bit_reg == 3'd7)
          begin
            if (st_reg == ST_DEVADDR)
            begin
              if (rx_byte[7:1] == my_addr)
              begin
                rw_next = rx_byte[0];
                st_next = ST_ACK;
                phase_next = 1'b0;
              end
              else
                st_next = ST_IDLE;
            end
            else if (st_reg == ST_REGADDR)
            begin
              ptr_next = rx_byte;
              st_next = ST_ACK;
              phase_next = 1'b1;
            end
            else
            begin
              wr_stb = 1'b1;
              // Write lands at the old pointer, then the pointer steps on
              ptr_next = ptr_reg + 8'd1;
              st_next = ST_ACK;
              phase_next = 1'b1;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall && !drv_reg)
            drv_next = 1'b1;
          else if (scl_fall && drv_reg)
          begin
            drv_next = 1'b0;
            bit_next = 3'd0;
            if (rw_reg && !phase_reg)
            begin
              rd_sh_next = rd_data;
              rd_stb = 1'b1;
              st_next = ST_RDATA;
            end
            else
              st_next = phase_reg | ~rw_reg ? (phase_reg ? ST_WDATA : ST_REGADDR) : ST_RDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_reg == 3'd7)
              st_next = ST_RACK;
            else
              rd_sh_next = {rd_sh_reg[6:0], 1'b0};
            bit_next = bit_reg + 3'd1;
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_f_reg)
              st_next = ST_IDLE;
            else
            begin
              ptr_next = ptr_reg + 8'd1;
              rw_next = 1'b1;
            end
          end
          else if (scl_fall && !sda_f_reg && rw_reg)
          begin
            rd_sh_next = rd_data;
            rd_stb = 1'b1;
            bit_next = 3'd0;
            st_next = ST_RDATA;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 3'd0;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      phase_reg <= 1'b0;
      rd_sh_reg <= 8'h00;
      drv_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      phase_reg <= phase_next;
      rd_sh_reg <= rd_sh_next;
      drv_reg <= drv_next;
    end
  end
  // Open drain: drive low for ack or for zero data bits, slave only
  assign sda_o = 1'b0;
  assign sda_oe_o = (st_reg == ST_ACK & drv_reg) | (st_reg == ST_RDATA & ~rd_sh_reg[7]);

  // ==========================================================
  // Register bank
  logic [2:0] mask_reg;
  logic [7:0] adv_cap_reg, aux_ilim_reg, aux_mon_reg, vbus_range_reg, sw_reset_reg;
  logic [7:0] disch_time_reg, disch_state_reg, pwr_mode_reg, vbus_mon_reg;
  logic [2:0] summary_reg;
  logic attach_chg_reg;
  logic [3:0] mon_chg_reg, mon_prev_reg;
  logic [7:0] fault_chg_reg, fault_prev_reg;
  logic attach_prev_reg;
  logic init_reg;
  wire [7:0] wdat = rx_byte;
  wire w_mask = wr_stb & (ptr_reg == ssarb_pkg::OFF_ALERT_MASK);
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mask_reg <= 3'b111;
      init_reg <= 1'b1;
      adv_cap_reg <= ssarb_pkg::RST_ZERO;
      aux_ilim_reg <= ssarb_pkg::RST_ZERO;
      aux_mon_reg <= ssarb_pkg::RST_ZERO;
      vbus_range_reg <= ssarb_pkg::RST_ZERO;
      sw_reset_reg <= ssarb_pkg::RST_ZERO;
      disch_time_reg <= ssarb_pkg::RST_ZERO;
      disch_state_reg <= ssarb_pkg::RST_ZERO;
      pwr_mode_reg <= ssarb_pkg::RST_ZERO;
      vbus_mon_reg <= ssarb_pkg::RST_ZERO;
    end
    else
    begin
      init_reg <= 1'b0;
      if (init_reg)
        mask_reg <= nvm_alert_mask_i;
      else if (w_mask)
        mask_reg <= wdat[6:4];
      if (wr_stb)
      begin
        case (ptr_reg)
          ssarb_pkg::OFF_ADV_CAP: adv_cap_reg <= wdat;
          ssarb_pkg::OFF_AUX_ILIM: aux_ilim_reg <= wdat;
          ssarb_pkg::OFF_AUX_MON: aux_mon_reg <= wdat;
          ssarb_pkg::OFF_VBUS_RANGE: vbus_range_reg <= wdat;
          ssarb_pkg::OFF_SW_RESET: sw_reset_reg <= wdat;
          ssarb_pkg::OFF_DISCH_TIME: disch_time_reg <= wdat;
          ssarb_pkg::OFF_DISCH_STATE: disch_state_reg <= wdat;
          ssarb_pkg::OFF_PWR_MODE: pwr_mode_reg <= wdat;
          ssarb_pkg::OFF_VBUS_MON: vbus_mon_reg <= wdat;
          default: ;
        endcase
      end
    end
  end
  logic standby_reg;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      standby_reg <= 1'b0;
    else if (init_reg)
      standby_reg <= nvm_standby_i;
  end
  assign sw_reset_o = sw_reset_reg;
  assign port_power_mode_o = pwr_mode_reg;

  // ==========================================================
  // Change flags and alert summary; set beats read-clear
  wire attach_bit = (attach_mode_i != ssarb_pkg::ATT_NONE);
  wire attach_ev = ~init_reg & (attach_bit ^ attach_prev_reg);
  wire [3:0] mon_ev = init_reg ? 4'h0 : (mon_state_i ^ mon_prev_reg);
  wire [7:0] fault_ev = init_reg ? 8'h00 : fault_event_i;
  wire clr_conn = rd_stb & (ptr_reg == ssarb_pkg::OFF_CONN_CHANGE);
  wire clr_mon = rd_stb & (ptr_reg == ssarb_pkg::OFF_MON_CHANGE);
  wire clr_fault = rd_stb & (ptr_reg == ssarb_pkg::OFF_FAULT_CHANGE);
  wire clr_sum = rd_stb & (ptr_reg == ssarb_pkg::OFF_ALERT_SUMMARY);
  wire [2:0] sum_ev = {attach_ev, |mon_ev, |fault_ev};
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      attach_prev_reg <= 1'b0;
      mon_prev_reg <= 4'h0;
      attach_chg_reg <= 1'b0;
      mon_chg_reg <= 4'h0;
      fault_chg_reg <= 8'h00;
      summary_reg <= 3'b000;
    end
    else
    begin
      attach_prev_reg <= attach_bit;
      mon_prev_reg <= mon_state_i;
      attach_chg_reg <= attach_ev | (attach_chg_reg & ~clr_conn);
      mon_chg_reg <= mon_ev | (mon_chg_reg & {4{~clr_mon}});
      fault_chg_reg <= fault_ev | (fault_chg_reg & {8{~clr_fault}});
      summary_reg <= (sum_ev & ~mask_reg) | (summary_reg & {3{~clr_sum}});
    end
  end
  assign alert_b_o = ~|(summary_reg & ~mask_reg);

  // ==========================================================
  // Source-role debug accessory detection
  wire both_rd = role_source_i & (channel_pin_one_i == ssarb_pkg::CC_RD) &
                 (channel_pin_two_i == ssarb_pkg::CC_RD);
  wire one_ra = role_source_i & ((channel_pin_one_i == ssarb_pkg::CC_RD & channel_pin_two_i == ssarb_pkg::CC_RA) |
                (channel_pin_two_i == ssarb_pkg::CC_RD & channel_pin_one_i == ssarb_pkg::CC_RA));
  logic [4:0] psc_reg;
  logic orient_reg;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      psc_reg <= ssarb_pkg::PSC_UNATT_SRC;
      orient_reg <= 1'b0;
    end
    else if (both_rd && psc_reg != ssarb_pkg::PSC_ORIENTED_DBG)
      psc_reg <= ssarb_pkg::PSC_UNORIENTED_DBG;
    else if (one_ra && psc_reg != ssarb_pkg::PSC_UNATT_SRC)
    begin
      psc_reg <= ssarb_pkg::PSC_ORIENTED_DBG;
      orient_reg <= (channel_pin_one_i == ssarb_pkg::CC_RA);
    end
    else if (!both_rd && !one_ra)
      psc_reg <= ssarb_pkg::PSC_UNATT_SRC;
  end
  wire in_dbg = (psc_reg == ssarb_pkg::PSC_UNORIENTED_DBG) | (psc_reg == ssarb_pkg::PSC_ORIENTED_DBG);
  assign source_debug_indicator_o = in_dbg;
  // Orientation pin pulls low when the Ra side is channel pin one; released otherwise
  assign orient_oe_o = (psc_reg == ssarb_pkg::PSC_ORIENTED_DBG) & orient_reg;

  // ==========================================================
  // Read mux
  ssarb_pkg::ssarb_conn_s conn;
  assign conn = '{attachment_type: attach_mode_i, standby: standby_reg, role_indicator: role_source_i,
                  aux_supply_active: aux_supply_active_i, attach_state_bit: attach_bit};
  always_comb
  begin
    case (ptr_reg)
      ssarb_pkg::OFF_ALERT_SUMMARY: rd_data = {1'b0, summary_reg, 4'h0};
      ssarb_pkg::OFF_ALERT_MASK: rd_data = {1'b1, mask_reg, 4'hf};
      ssarb_pkg::OFF_CONN_CHANGE: rd_data = {7'h00, attach_chg_reg};
      ssarb_pkg::OFF_CONN_STATE: rd_data = {conn.attachment_type, conn.standby, conn.role_indicator, 1'b0,
                                   conn.aux_supply_active, conn.attach_state_bit};
      ssarb_pkg::OFF_MON_CHANGE: rd_data = {4'h0, mon_chg_reg};
      ssarb_pkg::OFF_MON_STATE: rd_data = {4'h0, mon_state_i};
      ssarb_pkg::OFF_PORT_OP_STATE: rd_data = {orient_reg, 2'b00, psc_reg};
      ssarb_pkg::OFF_FAULT_CHANGE: rd_data = fault_chg_reg;
      ssarb_pkg::OFF_FAULT_STATE: rd_data = fault_state_i;
      ssarb_pkg::OFF_ADV_CAP: rd_data = adv_cap_reg;
      ssarb_pkg::OFF_AUX_ILIM: rd_data = aux_ilim_reg;
      ssarb_pkg::OFF_AUX_MON: rd_data = aux_mon_reg;
      ssarb_pkg::OFF_VBUS_RANGE: rd_data = vbus_range_reg;
      ssarb_pkg::OFF_SW_RESET: rd_data = sw_reset_reg;
      ssarb_pkg::OFF_DISCH_TIME: rd_data = disch_time_reg;
      ssarb_pkg::OFF_DISCH_STATE: rd_data = disch_state_reg;
      ssarb_pkg::OFF_PWR_PATH: rd_data = ssarb_pkg::RST_ZERO;
      ssarb_pkg::OFF_PWR_MODE: rd_data = pwr_mode_reg;
      ssarb_pkg::OFF_VBUS_MON: rd_data = vbus_mon_reg;
      default: rd_data = ssarb_pkg::RST_ZERO;
    endcase
  end

  // ==========================================================
  // Checks
  chk_alert_output: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    alert_b_o == ~|(summary_reg & ~mask_reg)) else $error("alert output mismatch");
  chk_summary_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (attach_ev && !mask_reg[2]) |=> summary_reg[2]) else $error("connection alert not set");
  chk_mask_block: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (mask_reg[0] && !summary_reg[0]) |=> !summary_reg[0] || !$past(mask_reg[0])) else $error("masked alert set");
  chk_attach_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    attach_ev |=> attach_chg_reg) else $error("attach change lost");
  chk_read_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (clr_mon && !(|mon_ev)) |=> mon_chg_reg == 4'h0) else $error("monitor flags not cleared");
  chk_mask_reads: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ptr_reg == ssarb_pkg::OFF_ALERT_MASK |-> rd_data[3:0] == 4'hf && rd_data[7]) else $error("mask reserved bits");
  chk_ro_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_stb && ptr_reg != ssarb_pkg::OFF_ALERT_MASK) |=> $stable(mask_reg)) else $error("mask changed");
  chk_debug_ind: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (both_rd && psc_reg == ssarb_pkg::PSC_UNATT_SRC) |=> source_debug_indicator_o) else $error("debug missed");
  chk_ack_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    sda_oe_o |-> st_reg == ST_ACK || st_reg == ST_RDATA) else $error("data line driven outside slot");
  // Read of the connection flags with no new event empties them
  sequence seq_conn_clear;
    clr_conn && !attach_ev;
  endsequence
  chk_conn_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    seq_conn_clear |=> !attach_chg_reg) else $error("connection flag not cleared");
endmodule
`default_nettype wire

// File: ssarb_master_model.sv
// Two-wire bus master model: bus clock and open-drain data line
`default_nettype none
module ssarb_master_model (
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF_NS = 400;
  // Long setup: the slave's filtered data path lags its clock edge detect
  localparam int SETUP_NS = 300;
  localparam int SAMPLE_NS = 200;
  localparam int HOLD_NS = 200;
  // Clock idles high outside frames
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Start or repeated start, data falls while clock high
  task automatic start();
    sda_pull_o = 1'b0;
    #(HALF_NS / 2);
    scl_o = 1'b1;
    #HALF_NS;
    sda_pull_o = 1'b1;
    #HALF_NS;
    scl_o = 1'b0;
    #(HALF_NS / 2);
  endtask
  task automatic stop();
    sda_pull_o = 1'b1;
    #(HALF_NS / 2);
    scl_o = 1'b1;
    #HALF_NS;
    sda_pull_o = 1'b0;
    #HALF_NS;
  endtask
  // One bit: data set early in low phase, sampled late in high phase
  task automatic clk_bit(input logic b, output logic s);
    sda_pull_o = ~b;
    #SETUP_NS;
    scl_o = 1'b1;
    #SAMPLE_NS;
    s = sda_i;
    #(2 * HALF_NS - SETUP_NS - SAMPLE_NS - HOLD_NS);
    scl_o = 1'b0;
    #HOLD_NS;
  endtask
  // Byte MSB first, then ninth bit; send all ones to read
  task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], r[i]);
    clk_bit(last, ack);
  endtask
endmodule
`default_nettype wire

// File: ssarb_top_bench.sv
// Self-checking bench: register access, alerts and debug detection
`default_nettype none
module ssarb_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic scl_i, sda_i, sda_o, sda_oe_o, address_select_pin_i, nvm_standby_i, role_source_i, aux_supply_active_i;
  logic alert_b_o, source_debug_indicator_o, orient_oe_o, m_pull, dlsb, ack;
  logic [2:0] nvm_alert_mask_i, attach_mode_i;
  logic [3:0] mon_state_i;
  logic [7:0] fault_state_i, fault_event_i, sw_reset_o, port_power_mode_o, q, v;
  logic [1:0] channel_pin_one_i, channel_pin_two_i;
  logic [7:0] rw_list [4] = '{8'h18, 8'h1e, 8'h20, 8'h2e};
  int n_errors = 0;
  int checked = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  // Open-drain data line with pull-up
  assign sda_i = ~(m_pull | sda_oe_o);
  ssarb_master_model mst (.scl_o(scl_i), .sda_pull_o(m_pull), .sda_i(sda_i));
  ssarb_top uut (.clk_sys_i, .rst_b_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .address_select_pin_i,
    .nvm_alert_mask_i, .nvm_standby_i, .role_source_i, .aux_supply_active_i, .attach_mode_i,
    .mon_state_i, .fault_state_i, .fault_event_i, .channel_pin_one_i, .channel_pin_two_i,
    .alert_b_o, .source_debug_indicator_o, .orient_oe_o, .sw_reset_o, .port_power_mode_o);
  // ==========================================
  // Checks and bus helpers
  function automatic logic [7:0] exp_mask(input logic [2:0] m);
    return {1'b1, m, 4'hf};
  endfunction
  function automatic logic [7:0] exp_conn();
    return {attach_mode_i, nvm_standby_i, role_source_i, 1'b0, aux_supply_active_i, |attach_mode_i};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic rd);
    mst.start();
    mst.xfer({6'h14, dlsb, 1'b0}, 1'b1, q, ack);
    chk(ack, 8'h00);
    mst.xfer(a, 1'b1, q, ack);
    chk(ack, 8'h00);
    if (rd)
    begin
      mst.start();
      mst.xfer({6'h14, dlsb, 1'b1}, 1'b1, q, ack);
      mst.xfer(8'hff, 1'b1, q, ack);
    end
    else
      mst.xfer(d, 1'b1, q, ack);
    mst.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    frame(a, 8'h00, 1'b1);
    chk(q, exp);
  endtask
  task automatic settle(input logic [2:0] mode, input logic [3:0] mon, input logic [7:0] evt);
    @(negedge clk_sys_i);
    attach_mode_i = mode;
    mon_state_i = mon;
    fault_event_i = evt;
    @(negedge clk_sys_i);
    fault_event_i = 8'h00;
    repeat (8) @(negedge clk_sys_i);
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #3_000_000;
    n_errors++;
    report_and_stop();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    v = 8'($urandom(25));
    nvm_alert_mask_i = 3'($urandom);
    nvm_standby_i = 1'($urandom);
    address_select_pin_i = 1'($urandom);
    aux_supply_active_i = 1'($urandom);
    fault_state_i = 8'($urandom);
    dlsb = ~address_select_pin_i;
    role_source_i = 1'b0;
    attach_mode_i = 3'h0;
    mon_state_i = 4'h0;
    fault_event_i = 8'h00;
    channel_pin_one_i = 2'h0;
    channel_pin_two_i = 2'h0;
    repeat (6) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk(alert_b_o, 8'h01);
    mst.start();
    mst.xfer({6'h14, dlsb, 1'b0}, 1'b1, q, ack);
    chk(ack, 8'h01);
    mst.stop();
    dlsb = address_select_pin_i;
    rd(ssarb_pkg::OFF_ALERT_MASK, exp_mask(nvm_alert_mask_i));
    rd(ssarb_pkg::OFF_CONN_STATE, exp_conn());
    rd(ssarb_pkg::OFF_FAULT_STATE, fault_state_i);
    frame(ssarb_pkg::OFF_CONN_STATE, ~exp_conn(), 1'b0);
    rd(ssarb_pkg::OFF_CONN_STATE, exp_conn());
    frame(8'h24, 8'hff, 1'b0);
    rd(8'h24, 8'h00);
    foreach (rw_list[i])
    begin
      v = 8'($urandom);
      frame(rw_list[i], v, 1'b0);
      rd(rw_list[i], v);
    end
    v = 8'($urandom);
    frame(ssarb_pkg::OFF_SW_RESET, v, 1'b0);
    chk(sw_reset_o, v);
    frame(ssarb_pkg::OFF_PWR_MODE, ~v, 1'b0);
    chk(port_power_mode_o, ~v);
    chk(sda_o, 8'h00);
    frame(ssarb_pkg::OFF_ALERT_MASK, 8'hbf, 1'b0);
    settle(ssarb_pkg::ATT_DEBUG, 4'h0, 8'h00);
    chk(alert_b_o, 8'h00);
    rd(ssarb_pkg::OFF_CONN_CHANGE, 8'h01);
    rd(ssarb_pkg::OFF_CONN_CHANGE, 8'h00);
    rd(ssarb_pkg::OFF_ALERT_SUMMARY, 8'h40);
    chk(alert_b_o, 8'h01);
    v = 8'($urandom) | 8'h01;
    settle(ssarb_pkg::ATT_DEBUG, 4'h0, v);
    chk(alert_b_o, 8'h01);
    rd(ssarb_pkg::OFF_FAULT_CHANGE, v);
    rd(ssarb_pkg::OFF_ALERT_SUMMARY, 8'h00);
    frame(ssarb_pkg::OFF_ALERT_MASK, 8'hdf, 1'b0);
    settle(ssarb_pkg::ATT_DEBUG, 4'h5, 8'h00);
    rd(ssarb_pkg::OFF_MON_CHANGE, 8'h05);
    rd(ssarb_pkg::OFF_ALERT_SUMMARY, 8'h20);
    role_source_i = 1'b1;
    channel_pin_one_i = 2'h1;
    channel_pin_two_i = 2'h1;
    repeat (20) @(negedge clk_sys_i);
    chk(source_debug_indicator_o, 8'h01);
    frame(ssarb_pkg::OFF_PORT_OP_STATE, 8'h00, 1'b1);
    chk(q[4:0], ssarb_pkg::PSC_UNORIENTED_DBG);
    channel_pin_two_i = 2'h2;
    repeat (20) @(negedge clk_sys_i);
    frame(ssarb_pkg::OFF_PORT_OP_STATE, 8'h00, 1'b1);
    chk(q[4:0], ssarb_pkg::PSC_ORIENTED_DBG);
    chk(orient_oe_o, 8'h00);
    channel_pin_one_i = 2'h2;
    channel_pin_two_i = 2'h1;
    repeat (20) @(negedge clk_sys_i);
    chk(orient_oe_o, 8'h01);
    chk(source_debug_indicator_o, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
